// ### dv/tb_wakeup_pending_latch.sv
// self-checking bench for the wake-up pending latch
`timescale 1ns/1ns
`include "wakeup_params.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t %h %h", $time, a, b); end end
module tb_wakeup_pending_latch import wakeup_pkg::*; ;
  logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, cyc, we, ack, hang;
  logic [7:0] adr, irq;
  logic [31:0] din, dout, pin = 32'h000f0000, ev, ev_acc, got, expq[$];
  bank_word_t v;
  int n_mismatch = 0, n_tests = 0;
  logic [23:0] su[14] = '{{8'h04, 16'h0}, {8'h24, 16'h0}, {8'h18, 16'h0}, {8'h38, 16'h0}, {8'h00, 16'h0},
    {8'h20, 16'hffff}, {8'h14, 16'hffff}, {8'h34, 16'hffff}, {8'h08, 16'h00e4}, {8'h28, 16'h00e4},
    {8'h18, 16'h000f}, {8'h38, 16'h000f}, {8'h04, 16'h000e}, {8'h24, 16'h000f}};
  always #10 clk = ~clk;
  wakeup_pending_latch wakeup_pending_latch_i (.clk(clk), .rst_n(rst_n), .clk_en(en), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(din), .wb_dat_o(dout),
    .wb_ack_o(ack), .wakeup_input_channel(pin), .wakeup_event(ev), .irq_line(irq));
  wk_cpu wk_cpu_i (.clk(clk), .cyc(cyc), .we(we), .adr(adr), .dat(din), .ack(ack), .hang(hang));
  always @(posedge clk) if (ack === 1'b1 && we === 1'b0) begin
    got = expq.pop_front();
    `CHK(dout, got)
  end
  // gathers every event pulse since reset
  always @(posedge clk) ev_acc <= rst_n ? (ev_acc | ev) : 32'h0;
  task automatic wr(input logic [7:0] a, input bank_word_t d);
    wk_cpu_i.acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input bank_word_t e);
    expq.push_back({16'h0, e});
    wk_cpu_i.acc(1'b0, a, 16'h0);
  endtask
  task automatic conclude;
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge hang) begin
    n_mismatch++;
    conclude();
  end
  initial begin
    void'($urandom(32'hde1f));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`WK_OFF_PEND_LOW, 16'h0);
    rd(`WK_OFF_PEND_HIGH, 16'h0);
    foreach (su[i]) wr(su[i][23:16], su[i][15:0]);
    // pins feed the wake-up inputs directly
    pin <= 32'h0000000f;
    repeat (8) @(posedge clk);
    rd(`WK_OFF_PEND_LOW, 16'h000e);
    rd(`WK_OFF_PEND_HIGH, 16'h000f);
    `CHK(irq, 8'hfe)
    `CHK(ev_acc, 32'h000f000e)
    v = 16'($urandom) & 16'hfff0;
    wr(`WK_OFF_PEND_LOW, v);
    rd(`WK_OFF_PEND_LOW, v | 16'h000e);
    wr(`WK_OFF_CLEAR_LOW, v | 16'h0002);
    rd(`WK_OFF_PEND_LOW, 16'h000c);
    rd(`WK_OFF_CLEAR_LOW, 16'h0);
    wr(8'h40, 16'hffff);
    rd(8'h40, 16'h0);
    wr(`WK_OFF_IRQEN_HIGH, 16'h0);
    rd(`WK_OFF_PEND_HIGH, 16'h000f);
    `CHK(irq, 8'h0c)
    wr(`WK_OFF_ENABLE_LOW, 16'h0006);
    wr(`WK_OFF_EDGE_LOW, 16'h0008);
    wr(`WK_OFF_CLEAR_LOW, 16'h0008);
    rd(`WK_OFF_PEND_LOW, 16'h0004);
    wr(`WK_OFF_ENABLE_LOW, 16'h000e);
    pin <= 32'h0;
    repeat (8) @(posedge clk);
    rd(`WK_OFF_PEND_LOW, 16'h000c);
    en <= 1'b0;
    pin <= 32'h00000002;
    repeat (8) @(posedge clk);
    `CHK(irq, 8'h0c)
    en <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`WK_OFF_PEND_LOW, 16'h000e);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`WK_OFF_PEND_LOW, 16'h0);
    `CHK(irq, 8'h00)
    repeat (2) @(posedge clk);
    conclude();
  end
endmodule

// ### dv/wakeup_pending_latch_asserts.sv
// port assertions for the wake-up pending latch
`timescale 1ns/1ns
`include "wakeup_params.svh"
module wk_chk (
  // clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // bus and outputs
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [31:0] wakeup_event,
  input wire logic [7:0] irq_line
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !clk_en);
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd_take = take && !wb_we_i;
  wire clr_adr = wb_adr_i == `WK_OFF_CLEAR_LOW || wb_adr_i == `WK_OFF_CLEAR_HIGH;
  property p_ack; take |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_one: assert property (p_one) else $error("ack longer than one cycle");
  property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside ack");
  property p_top; wb_dat_o[31:16] == 16'h0; endproperty
  a_top: assert property (p_top) else $error("upper read bits set");
  property p_clr; rd_take && clr_adr |=> wb_dat_o == 32'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear register read not zero");
  property p_unm; rd_take && wb_adr_i == 8'h40 |=> wb_dat_o == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_ev; (wakeup_event & $past(wakeup_event)) == 32'h0; endproperty
  a_ev: assert property (p_ev) else $error("event longer than one cycle");
  property p_irq; |($past(irq_line) & ~irq_line) |-> wb_ack_o || $past(wb_ack_o) || !$past(rst_n); endproperty
  a_irq: assert property (p_irq) else $error("request line fell without a write");
  c_wr: cover property (take && wb_we_i);
  c_ev: cover property (|wakeup_event);
  c_irq: cover property (|irq_line);
endmodule
bind wakeup_pending_latch wk_chk wk_chk_i (.clk, .rst_n, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .wakeup_event, .irq_line);

// ### dv/wk_cpu.sv
// wishbone master standing in for the cpu
`timescale 1ns/1ns
module wk_cpu (
  // clock
  input wire logic clk,
  // wishbone master
  output logic cyc,
  output logic we,
  output logic [7:0] adr,
  output logic [31:0] dat,
  input wire logic ack,
  // wait ran out
  output logic hang
);
  initial begin
    cyc = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
    hang = 1'b0;
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0, d};
    for (n = 0; n < 50 && ack !== 1'b1; n++) @(posedge clk);
    if (n == 50) hang <= 1'b1;
    cyc <= 1'b0;
    adr <= ~a;
    dat <= ~{16'h0, d};
    @(posedge clk);
  endtask
endmodule

// ### src/wakeup_params.svh
// register offsets, reset values and field constants of the wake-up pending latch
`ifndef WAKEUP_PARAMS_SVH
`define WAKEUP_PARAMS_SVH
`define WK_OFF_EDGE_LOW 8'h00
`define WK_OFF_ENABLE_LOW 8'h04
`define WK_OFF_SEL_LOW_A 8'h08
`define WK_OFF_SEL_LOW_B 8'h0c
`define WK_OFF_PEND_LOW 8'h10
`define WK_OFF_CLEAR_LOW 8'h14
`define WK_OFF_IRQEN_LOW 8'h18
`define WK_OFF_EDGE_HIGH 8'h20
`define WK_OFF_ENABLE_HIGH 8'h24
`define WK_OFF_SEL_HIGH_A 8'h28
`define WK_OFF_SEL_HIGH_B 8'h2c
`define WK_OFF_PEND_HIGH 8'h30
`define WK_OFF_CLEAR_HIGH 8'h34
`define WK_OFF_IRQEN_HIGH 8'h38
`define WK_RESET_16 16'h0000
`define WK_BANK_BITS 16
`define WK_SEL_BITS 2
`define WK_LINES 8
`endif

// ### src/wakeup_pending_latch.sv
// wake-up pending latch with wishbone register file
`timescale 1ns/1ns
`include "wakeup_params.svh"

module wakeup_pending_latch
  import wakeup_pkg::*;
#(
  parameter int CHANNELS = 32
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // wake-up inputs and outputs
  input wire logic [31:0] wakeup_input_channel,
  output logic [31:0] wakeup_event,
  output logic [7:0] irq_line
);

  // only the two-bank layout is served
  if (CHANNELS != 2 * `WK_BANK_BITS) begin : g_bad_channels
    $error("wakeup_pending_latch supports exactly 32 channels");
  end

  localparam int BANK = `WK_BANK_BITS;

  // configuration and state
  bank_word_t edge_reg_low, edge_reg_high;
  bank_word_t enable_reg_low, enable_reg_high;
  bank_word_t irq_enable_reg_low, irq_enable_reg_high;
  bank_word_t irq_select_reg_low_a, irq_select_reg_low_b;
  bank_word_t irq_select_reg_high_a, irq_select_reg_high_b;
  logic [31:0] pending_flag_reg;
  logic [31:0] pending_flag_next;
  logic [31:0] sync1_reg, sync2_reg, sync3_reg;
  logic [31:0] dat_reg;
  logic ack_reg;
  logic [31:0] event_reg;
  logic [7:0] irq_reg;

  // bus decode
  wire logic req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire logic wr = req & wb_we_i;
  wire logic lane_lo = wb_sel_i[0];
  wire logic lane_hi = wb_sel_i[1];
  wire logic [15:0] lane_mask = {{8{lane_hi}}, {8{lane_lo}}};
  wire logic [15:0] wdata = wb_dat_i[15:0] & lane_mask;
  wire logic hit_edge_lo = wb_adr_i == `WK_OFF_EDGE_LOW;
  wire logic hit_edge_hi = wb_adr_i == `WK_OFF_EDGE_HIGH;
  wire logic hit_en_lo = wb_adr_i == `WK_OFF_ENABLE_LOW;
  wire logic hit_en_hi = wb_adr_i == `WK_OFF_ENABLE_HIGH;
  wire logic hit_sla = wb_adr_i == `WK_OFF_SEL_LOW_A;
  wire logic hit_slb = wb_adr_i == `WK_OFF_SEL_LOW_B;
  wire logic hit_sha = wb_adr_i == `WK_OFF_SEL_HIGH_A;
  wire logic hit_shb = wb_adr_i == `WK_OFF_SEL_HIGH_B;
  wire logic hit_pnd_lo = wb_adr_i == `WK_OFF_PEND_LOW;
  wire logic hit_pnd_hi = wb_adr_i == `WK_OFF_PEND_HIGH;
  wire logic hit_clr_lo = wb_adr_i == `WK_OFF_CLEAR_LOW;
  wire logic hit_clr_hi = wb_adr_i == `WK_OFF_CLEAR_HIGH;
  wire logic hit_ie_lo = wb_adr_i == `WK_OFF_IRQEN_LOW;
  wire logic hit_ie_hi = wb_adr_i == `WK_OFF_IRQEN_HIGH;
  // ack_reg masks the held request so one access answers once
  wire logic rd_req = req & ~wb_we_i;
  wire logic [15:0] wdata_raw = wb_dat_i[15:0];

  // write strobes, one per configuration register
  wire logic we_edge_lo = wr & hit_edge_lo;
  wire logic we_edge_hi = wr & hit_edge_hi;
  wire logic we_en_lo = wr & hit_en_lo;
  wire logic we_en_hi = wr & hit_en_hi;
  wire logic we_ie_lo = wr & hit_ie_lo;
  wire logic we_ie_hi = wr & hit_ie_hi;
  wire logic we_sla = wr & hit_sla;
  wire logic we_slb = wr & hit_slb;
  wire logic we_sha = wr & hit_sha;
  wire logic we_shb = wr & hit_shb;

  // merge a write into a register under byte lanes
  function automatic bank_word_t merge(input bank_word_t old, input bank_word_t nw, input logic [15:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // read mux; clear registers read as zero
  // clear reads return zero
  wire logic [15:0] rdata =
    hit_edge_lo ? edge_reg_low :
    hit_edge_hi ? edge_reg_high :
    hit_en_lo ? enable_reg_low :
    hit_en_hi ? enable_reg_high :
    hit_sla ? irq_select_reg_low_a :
    hit_slb ? irq_select_reg_low_b :
    hit_sha ? irq_select_reg_high_a :
    hit_shb ? irq_select_reg_high_b :
    hit_pnd_lo ? pending_flag_reg[15:0] :
    hit_pnd_hi ? pending_flag_reg[31:16] :
    hit_ie_lo ? irq_enable_reg_low :
    hit_ie_hi ? irq_enable_reg_high : `WK_RESET_16;

  // concatenated per-channel views
  // channel order
  wire logic [31:0] edge_all = {edge_reg_high, edge_reg_low};
  wire logic [31:0] enable_all = {enable_reg_high, enable_reg_low};
  wire logic [31:0] irqen_all = {irq_enable_reg_high, irq_enable_reg_low};
  wire logic [63:0] sel_all = {irq_select_reg_high_b, irq_select_reg_high_a,
                               irq_select_reg_low_b, irq_select_reg_low_a};

  // software set and clear masks
  // write one sets
  wire logic [31:0] sw_set = {wr & hit_pnd_hi ? wdata : `WK_RESET_16,
                              wr & hit_pnd_lo ? wdata : `WK_RESET_16};
  wire logic [31:0] sw_clr = {wr & hit_clr_hi ? wdata : `WK_RESET_16,
                              wr & hit_clr_lo ? wdata : `WK_RESET_16};

  logic [31:0] hw_set;
  logic [7:0] irq_next;

  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_chan
      // rise and fall compare stage 3 with the newer stage 2
      // edge polarity select
      wire logic rise = sync3_reg[i] == 1'b0 && sync2_reg[i] == 1'b1;
      wire logic fall = sync3_reg[i] == 1'b1 && sync2_reg[i] == 1'b0;
      assign hw_set[i] = enable_all[i] & (edge_all[i] ? fall : rise);
    end
  endgenerate

  // latch and hold
  // a clear never hides a trigger landing in the same cycle
  assign pending_flag_next = (pending_flag_reg & ~sw_clr) | sw_set | hw_set;

  // interrupt line routing, lines 0-3 low bank, 4-7 high bank
  genvar k;
  for (k = 0; k < 8; k++) begin : g_line
    logic hit;
    always_comb begin
      hit = 1'b0;
      for (int c = 0; c < BANK; c++) begin
        if (pending_flag_reg[(k / 4) * BANK + c] && irqen_all[(k / 4) * BANK + c] &&
            sel_all[2 * ((k / 4) * BANK + c) +: 2] == 2'(k % 4)) begin
          hit = 1'b1;
        end
      end
    end
    assign irq_next[k] = hit;
  end

  // stage 1 may go metastable; only stages 2 and 3 feed edge logic
  // synchroniser for outside inputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= 32'h0;
      sync2_reg <= 32'h0;
      sync3_reg <= 32'h0;
    end else if (clk_en) begin
      sync1_reg <= wakeup_input_channel;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // pending state
  // pending reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pending_flag_reg <= 32'h0;
    end else if (clk_en) begin
      pending_flag_reg <= pending_flag_next;
    end
  end

  // one-cycle wake-up event per detected edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      event_reg <= 32'h0;
    end else if (clk_en) begin
      event_reg <= hw_set;
    end
  end

  // registered request lines
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_reg <= 8'h00;
    end else if (clk_en) begin
      irq_reg <= irq_next;
    end
  end

  // edge select, low bank
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      edge_reg_low <= `WK_RESET_16;
    end else if (clk_en && we_edge_lo) begin
      edge_reg_low <= merge(edge_reg_low, wdata_raw, lane_mask);
    end
  end

  // edge select, high bank
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      edge_reg_high <= `WK_RESET_16;
    end else if (clk_en && we_edge_hi) begin
      edge_reg_high <= merge(edge_reg_high, wdata_raw, lane_mask);
    end
  end

  // channel enable, low bank
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_reg_low <= `WK_RESET_16;
    end else if (clk_en && we_en_lo) begin
      enable_reg_low <= merge(enable_reg_low, wdata_raw, lane_mask);
    end
  end

  // channel enable, high bank
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_reg_high <= `WK_RESET_16;
    end else if (clk_en && we_en_hi) begin
      enable_reg_high <= merge(enable_reg_high, wdata_raw, lane_mask);
    end
  end

  // interrupt enable, low bank
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_enable_reg_low <= `WK_RESET_16;
    end else if (clk_en && we_ie_lo) begin
      irq_enable_reg_low <= merge(irq_enable_reg_low, wdata_raw, lane_mask);
    end
  end

  // interrupt enable, high bank
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_enable_reg_high <= `WK_RESET_16;
    end else if (clk_en && we_ie_hi) begin
      irq_enable_reg_high <= merge(irq_enable_reg_high, wdata_raw, lane_mask);
    end
  end

  // line select, channels 7..0
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_select_reg_low_a <= `WK_RESET_16;
    end else if (clk_en && we_sla) begin
      irq_select_reg_low_a <= merge(irq_select_reg_low_a, wdata_raw, lane_mask);
    end
  end

  // line select, channels 15..8
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_select_reg_low_b <= `WK_RESET_16;
    end else if (clk_en && we_slb) begin
      irq_select_reg_low_b <= merge(irq_select_reg_low_b, wdata_raw, lane_mask);
    end
  end

  // line select, channels 23..16
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_select_reg_high_a <= `WK_RESET_16;
    end else if (clk_en && we_sha) begin
      irq_select_reg_high_a <= merge(irq_select_reg_high_a, wdata_raw, lane_mask);
    end
  end

  // line select, channels 31..24
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_select_reg_high_b <= `WK_RESET_16;
    end else if (clk_en && we_shb) begin
      irq_select_reg_high_b <= merge(irq_select_reg_high_b, wdata_raw, lane_mask);
    end
  end

  // bus answer, one cycle after request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else if (clk_en) begin
      ack_reg <= req;
    end
  end

  // read data stands only with a read ack, zero otherwise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dat_reg <= 32'h0;
    end else if (clk_en) begin
      dat_reg <= rd_req ? {16'h0000, rdata} : 32'h0;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign wakeup_event = event_reg;
  assign irq_line = irq_reg;

endmodule

// ### src/wakeup_pkg.sv
// types shared by the wake-up pending latch
package wakeup_pkg;
  typedef logic [15:0] bank_word_t;
  typedef logic [1:0] irq_sel_t;
endpackage
